// ---- rtl/drc_ctrl.sv ----
// strobe-cycle controller driving an 8K x 1 multiplexed-address memory
`timescale 1ns/1ps
// Notes on behaviour
// (RL1) eight refreshing cycles after power-up or long idle
// (RL2) read data valid after row access time
// (RL3) early write keeps device output off
// (RL4) late write after 95/160 ns reads first
// (RL5) other write timings leave output undefined
// (RL6) column-only precharge applies after column-only cycles
// (RL7) write strobe high after read strobe rise
// (RL8) write data setup/hold around later falling edge
// (RL9) cycles start at least 375 ns apart
// (RL10) write strobe high before column strobe in reads
// (RL11) write strobe low at least 55 ns
// (RL12) write strobe low 120 ns from row strobe
// (RL13) write data held 120 ns from row strobe
// (RL14) all 64 rows refreshed every 2 ms
// (RL15) output latched while column strobe low
// (RL16) hidden refresh with column strobe held low
// (RL17) top address line fixed during row address
// (RL18) row strobe 200..10000 ns low, 120 ns high
// (RL19) refresh counter and interval timer built in
module drc_ctrl
    import drc_pkg::*;
#(
    parameter logic HALF_SELECT = 1'b1,      // array half level for row phase
    parameter int   REF_INTERVAL = REF_INT_CYC // cycles between row refreshes
) (
    input  wire logic        CLK_IN,         // 20 MHz system clock
    input  wire logic        RESET_IN,       // synchronous reset, active high
    input  wire logic        REQ_VALID_IN,   // user request present
    input  wire logic [1:0]  REQ_CMD_IN,     // read, write or read-modify-write
    input  wire logic [12:0] REQ_ADDR_IN,    // word address
    input  wire logic        REQ_WDATA_IN,   // write data bit
    output logic             REQ_READY_OUT,  // high the cycle after a request is taken
    output logic             RD_VALID_OUT,   // one-cycle pulse, read data valid
    output logic             RD_DATA_OUT,    // captured read bit
    output logic             INIT_DONE_OUT,  // warm-up cycles complete
    output logic             RAS_N_OUT,      // row strobe, active low
    output logic             CAS_N_OUT,      // column strobe, active low
    output logic             WE_N_OUT,       // write strobe, active low
    output logic [6:0]       ADDR_OUT,       // multiplexed address lines
    output logic             DIN_OUT,        // data into the memory
    input  wire logic        DOUT_IN         // data from the memory pin
);
    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    drc_state_t  state_r, state_nxt;   // sequencer state
    logic [4:0]  tcnt_r;               // cycles since row strobe fall, or within precharge
    logic        is_ref_r;             // current cycle is row-only refresh
    drc_cmd_t    cmd_r;                // command being executed
    logic [12:0] addr_r;               // latched word address
    logic        wdata_r;              // latched write bit
    logic [5:0]  ref_row_r;            // next row to refresh
    logic [3:0]  warm_r;               // warm-up cycles issued
    logic        ras_n_r, cas_n_r, we_n_r, din_r, ready_r, rdv_r, rdd_r;
    logic [6:0]  addr_out_r;
    logic        dq_s1_r, dq_s2_r;     // pin synchroniser
    logic        refresh_due;          // timer request
    logic [1:0]  rd_pipe_r;            // read sample moving with the pin
    logic        init_r;               // registered warm-up complete

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    wire warm_done  = (warm_r == 4'(WARMUP_CYCLES));
    wire need_ref   = refresh_due || !warm_done;            // see (RL1)
    wire take_req   = (state_r == DRC_ST_IDLE) && !need_ref && REQ_VALID_IN;
    wire start_cyc  = (state_r == DRC_ST_IDLE) && (need_ref || REQ_VALID_IN);
    wire is_rd      = (cmd_r != DRC_CMD_WRITE);
    wire is_rmw     = (cmd_r == DRC_CMD_RMW);
    // row phase: low six bits plus fixed half select; column: the rest.
    // the row comes from the request or refresh counter directly, as the
    // latched copies load on the very edge that drops the row strobe
    wire [5:0] row_sel  = need_ref ? ref_row_r : REQ_ADDR_IN[5:0];
    wire [6:0] row_addr = {HALF_SELECT, row_sel};            // see (RL17)
    wire [6:0] col_addr = addr_r[12:6];
    // row strobe low long enough for access, late write, and minimum pulse
    localparam int ROW_LOW = (RWD_CYC + WP_CYC > RAS_CYC + 1)
                             ? RWD_CYC + WP_CYC : RAS_CYC + 1;
    // precharge long enough for both the row high time and the cycle time
    localparam int PRE_CYC = (RC_CYC - ROW_LOW > RP_CYC)
                             ? RC_CYC - ROW_LOW : RP_CYC;
    wire row_end   = (tcnt_r == 5'(ROW_LOW - 1));
    wire pre_end   = (tcnt_r == 5'(PRE_CYC - 1));
    wire cas_at    = (tcnt_r == 5'(RCD_CYC - 1));
    wire sample_at = (tcnt_r == 5'(ACC_CYC));               // see (RL2)
    // first read sample: one edge past the access time, column still low
    wire rd_mark   = (state_r == DRC_ST_COL) && is_rd && !is_ref_r
                     && sample_at;                          // see (RL5)
    // write strobe windows counted from row strobe fall; a strobe moves
    // on the edge after tcnt is seen, hence the minus one on late write
    wire early_we  = !is_rd && (tcnt_r <= 5'(WCR_CYC));     // see (RL12)
    wire late_we   = is_rmw && (tcnt_r >= 5'(RWD_CYC - 1))
                     && (tcnt_r >= 5'(RCD_CYC + CWD_CYC - 1)); // see (RL4)

    // -----------------------------------------------------------------
    // refresh interval timer
    // -----------------------------------------------------------------
    drc_refresh_timer #(
        .INTERVAL        (REF_INTERVAL)
    ) u_timer (
        .clk_in          (CLK_IN),
        .reset_in        (RESET_IN),
        .refresh_done_in (start_cyc && need_ref && warm_done),
        .refresh_due_out (refresh_due)
    );

    // -----------------------------------------------------------------
    // next-state logic
    // -----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DRC_ST_IDLE:  if (start_cyc) state_nxt = DRC_ST_ROW;
            DRC_ST_ROW:   if (is_ref_r ? row_end : cas_at)
                              state_nxt = is_ref_r ? DRC_ST_PRECH : DRC_ST_COL;
            DRC_ST_COL:   if (row_end) state_nxt = DRC_ST_PRECH;
            DRC_ST_PRECH: if (pre_end) state_nxt = DRC_ST_IDLE; // see (RL9)
            default:      state_nxt = DRC_ST_IDLE;
        endcase
    end

    // -----------------------------------------------------------------
    // sequencer, counters and request capture
    // -----------------------------------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            state_r   <= DRC_ST_IDLE;
            tcnt_r    <= '0;
            is_ref_r  <= 1'b0;
            cmd_r     <= DRC_CMD_READ;
            addr_r    <= '0;
            wdata_r   <= 1'b0;
            ref_row_r <= '0;
            warm_r    <= '0;
        end else begin
            state_r <= state_nxt;
            tcnt_r  <= (state_nxt != state_r && state_nxt != DRC_ST_COL)
                       ? '0 : tcnt_r + 1'b1;
            if (start_cyc) begin
                is_ref_r <= need_ref;
                if (need_ref) begin
                    ref_row_r <= ref_row_r + 1'b1;           // see (RL14)
                    if (!warm_done)
                        warm_r <= warm_r + 1'b1;             // see (RL1)
                end
            end
            if (take_req) begin
                cmd_r   <= drc_cmd_t'(REQ_CMD_IN);
                addr_r  <= REQ_ADDR_IN;
                wdata_r <= REQ_WDATA_IN;
            end
        end
    end

    // -----------------------------------------------------------------
    // pin drive: strobes never glitch since each is a flip-flop
    // -----------------------------------------------------------------
    wire ras_low = (state_nxt == DRC_ST_ROW) || (state_nxt == DRC_ST_COL);
    wire cas_low = (state_nxt == DRC_ST_COL);  // column strobe only in COL
    wire we_low  = (state_nxt == DRC_ST_COL || state_nxt == DRC_ST_ROW)
                   && !is_ref_r && state_r != DRC_ST_IDLE
                   && (early_we || late_we);
    // new bit goes out with the row strobe fall, ahead of the column and
    // write strobe edges at which the memory takes it
    wire din_nxt = take_req ? REQ_WDATA_IN : wdata_r;
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            ras_n_r    <= 1'b1;
            cas_n_r    <= 1'b1;
            we_n_r     <= 1'b1;
            addr_out_r <= '0;
            din_r      <= 1'b0;
        end else begin
            ras_n_r    <= !ras_low;                          // see (RL18)
            // column strobe rises with row strobe, so no column-only cycle
            cas_n_r    <= !cas_low;                          // see (RL6)
            // reads keep write strobe high through both strobe edges
            we_n_r     <= !we_low;                  // see (RL7) see (RL10)
            // row address loads as the row strobe falls and stands until
            // the column phase replaces it, so it never moves under the strobe
            if (start_cyc)
                addr_out_r <= row_addr;
            else if (state_nxt == DRC_ST_COL)
                addr_out_r <= col_addr;
            // data held from the row strobe fall to the next request
            din_r      <= din_nxt;                  // see (RL8) see (RL13)
        end
    end
    // write strobe low spans four cycles in early write and two in late write, beyond the pulse minimum
    // see (RL11)

    // -----------------------------------------------------------------
    // read data: pin synchronised, sampled only in read-type cycles
    // -----------------------------------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            dq_s1_r <= 1'b0;
            dq_s2_r <= 1'b0;
            rdv_r     <= 1'b0;
            rdd_r     <= 1'b0;
            ready_r   <= 1'b0;
            init_r    <= 1'b0;
            rd_pipe_r <= 2'h0;
        end else begin
            dq_s1_r   <= DOUT_IN;
            dq_s2_r   <= dq_s1_r;
            ready_r   <= take_req;
            init_r    <= warm_done;
            // the pin enters the first stage at the sample point and
            // leaves the second two edges later; the output stays
            // latched while the column strobe is low        see (RL15)
            rd_pipe_r <= {rd_pipe_r[0], rd_mark};
            rdv_r     <= rd_pipe_r[1];
            if (rd_pipe_r[1])
                rdd_r <= dq_s2_r;
        end
    end

    assign REQ_READY_OUT = ready_r;
    assign RD_VALID_OUT  = rdv_r;
    assign RD_DATA_OUT   = rdd_r;
    assign INIT_DONE_OUT = init_r;      // see (RL3) writes never sample
    assign RAS_N_OUT     = ras_n_r;
    assign CAS_N_OUT     = cas_n_r;
    assign WE_N_OUT      = we_n_r;
    assign ADDR_OUT      = addr_out_r;
    assign DIN_OUT       = din_r;
    // hidden refresh is not issued; refreshes use row-only cycles  see (RL16)
endmodule : drc_ctrl

// ---- rtl/drc_pkg.sv ----
// package: timing constants and enums for the strobe-cycle memory controller
package drc_pkg;
    localparam int CLK_PERIOD_NS    = 50;
    // device timing, faster grade, in ns
    localparam int RAS_PULSE_NS     = 200;    // row strobe low, minimum
    localparam int RAS_PULSE_MAX_NS = 10000;  // row strobe low, maximum
    localparam int ROW_PRECH_NS     = 120;    // row strobe high between cycles
    localparam int RCD_NS           = 50;     // row to column strobe delay
    localparam int CYCLE_NS         = 375;    // random cycle time
    localparam int ACCESS_NS        = 200;    // access time from row strobe
    localparam int WR_HOLD_ROW_NS   = 120;    // write strobe hold from row
    localparam int WR_PULSE_NS      = 55;     // write strobe pulse width
    localparam int RMW_ROW_WR_NS    = 160;    // row strobe to write strobe
    localparam int RMW_COL_WR_NS    = 95;     // column strobe to write strobe
    localparam int REFRESH_MS       = 2;      // refresh period per row
    localparam int WARMUP_CYCLES    = 8;      // cycles needed after idle
    localparam int ROWS             = 64;     // rows needing refresh
    // cycle counts; least times round up
    localparam int RAS_CYC  = (RAS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_CYC   = (ROW_PRECH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RCD_CYC  = (RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RC_CYC   = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC  = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WCR_CYC  = (WR_HOLD_ROW_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int WP_CYC   = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RWD_CYC  = (RMW_ROW_WR_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int CWD_CYC  = (RMW_COL_WR_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    // refresh interval per row: period / rows, rounded down
    localparam int REF_INT_CYC = (REFRESH_MS * 1000000 / ROWS) / CLK_PERIOD_NS;
    // command codes
    typedef enum logic [1:0] {
        DRC_CMD_READ  = 2'h0,
        DRC_CMD_WRITE = 2'h1,
        DRC_CMD_RMW   = 2'h2
    } drc_cmd_t;
    // sequencer states
    typedef enum logic [2:0] {
        DRC_ST_IDLE  = 3'h0,
        DRC_ST_ROW   = 3'h1,
        DRC_ST_COL   = 3'h2,
        DRC_ST_PRECH = 3'h3
    } drc_state_t;
endpackage : drc_pkg

// ---- rtl/drc_refresh_timer.sv ----
// refresh interval timer and pending-refresh flag
`timescale 1ns/1ps
module drc_refresh_timer
    import drc_pkg::*;
#(
    parameter int INTERVAL = REF_INT_CYC   // cycles between row refreshes
) (
    input  wire logic clk_in,        // system clock
    input  wire logic reset_in,      // synchronous reset, active high
    input  wire logic refresh_done_in, // a refresh cycle was started
    output logic      refresh_due_out  // a refresh is owed
);
    localparam int CW = $clog2(INTERVAL + 1);
    logic [CW-1:0] count_r;   // cycles since last interval mark
    logic          due_r;     // pending refresh flag
    wire           tick = (count_r == CW'(INTERVAL - 1));

    // -----------------------------------------------------------------
    // interval counter; a new tick wins over a simultaneous completion
    // -----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            count_r <= '0;
            due_r   <= 1'b0;
        end else begin
            count_r <= tick ? '0 : count_r + 1'b1;
            if (tick)
                due_r <= 1'b1;          // see (RL19)
            else if (refresh_done_in)
                due_r <= 1'b0;
        end
    end
    assign refresh_due_out = due_r;
endmodule : drc_refresh_timer

// ---- dv/drc_ctrl_chk.sv ----
// assertion checker for the strobe-cycle memory controller
`timescale 1ns/1ps
module drc_ctrl_chk
    import drc_pkg::*;
#(
    parameter logic HALF_SELECT  = 1'b1, // row-phase array half level
    parameter int   REF_INTERVAL = 50    // cycles between row refreshes
) (
    input  wire logic       CLK_IN,        // system clock
    input  wire logic       RESET_IN,      // sync reset, active high
    input  wire logic       REQ_READY_OUT, // request taken
    input  wire logic       RAS_N_OUT,     // row strobe
    input  wire logic       CAS_N_OUT,     // column strobe
    input  wire logic       WE_N_OUT,      // write strobe
    input  wire logic [6:0] ADDR_OUT,      // muxed address
    input  wire logic       DIN_OUT        // write data
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    logic [7:0]  ras_age_r;  // cycles since row strobe fell
    logic [3:0]  cas_age_r;  // cycles since column strobe fell
    logic [3:0]  fall_cnt_r; // row strobe falls since reset
    logic [15:0] gap_r;      // cycles since last row strobe fall
    // counters saturate so a long idle cannot wrap them to small values
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            ras_age_r  <= 8'h00;
            cas_age_r  <= 4'h0;
            fall_cnt_r <= 4'h0;
            gap_r      <= 16'h0000;
        end else begin
            ras_age_r  <= $fell(RAS_N_OUT) ? 8'h01
                          : ras_age_r + 8'(ras_age_r != 8'hFF);
            cas_age_r  <= $fell(CAS_N_OUT) ? 4'h1
                          : cas_age_r + 4'(cas_age_r != 4'hF);
            fall_cnt_r <= fall_cnt_r
                          + 4'($fell(RAS_N_OUT) && fall_cnt_r != 4'hF);
            gap_r      <= $fell(RAS_N_OUT) ? 16'h0000
                          : gap_r + 16'(gap_r != 16'hFFFF);
        end
    end
    // ------------------------------------------------------------
    // strobe timing
    // ------------------------------------------------------------
    sequence s_row_low;   !RAS_N_OUT [*4]; endsequence // 200 ns active
    sequence s_row_prech; RAS_N_OUT [*3];  endsequence // 150 ns precharge
    chk_half_sel:
        assert property ($fell(RAS_N_OUT) |-> ADDR_OUT[6] == HALF_SELECT)
        else $error("top address line wrong at row strobe");
    chk_row_low:
        assert property ($fell(RAS_N_OUT) |-> s_row_low)
        else $error("row strobe pulse too short");
    chk_row_max:
        assert property ($fell(RAS_N_OUT) |-> ##[1:200] $rose(RAS_N_OUT))
        else $error("row strobe pulse too long");
    chk_row_prech:
        assert property ($rose(RAS_N_OUT) |-> s_row_prech)
        else $error("row precharge too short");
    chk_cycle_gap:
        assert property ($fell(RAS_N_OUT) |=> (!$fell(RAS_N_OUT)) [*7])
        else $error("cycles start too close");
    chk_col_in_row:
        assert property ($fell(CAS_N_OUT) |-> !RAS_N_OUT)
        else $error("column strobe without row strobe");
    chk_we_pulse:
        assert property ($fell(WE_N_OUT) |-> !WE_N_OUT [*2])
        else $error("write strobe pulse too short");
    chk_we_row_hold:
        assert property ($rose(WE_N_OUT) |-> ras_age_r >= 8'h03)
        else $error("write strobe released too early");
    chk_din_hold:
        assert property (!WE_N_OUT && !$past(WE_N_OUT) |-> $stable(DIN_OUT))
        else $error("write data moved during write");
    chk_write_mode:
        assert property ($fell(WE_N_OUT) |-> CAS_N_OUT || $fell(CAS_N_OUT)
                         || (cas_age_r >= 4'h2 && ras_age_r >= 8'h04))
        else $error("write strobe neither early nor late");
    chk_refresh_gap:
        assert property (gap_r <= 16'(REF_INTERVAL + 2 * RC_CYC))
        else $error("refresh interval overrun");
    chk_warm_up:
        assert property (REQ_READY_OUT |-> fall_cnt_r >= 4'h8)
        else $error("request taken before warm-up");
endmodule : drc_ctrl_chk
bind drc_ctrl drc_ctrl_chk #(
    .HALF_SELECT(HALF_SELECT), .REF_INTERVAL(REF_INTERVAL)
) drc_ctrl_chk_inst (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
    .REQ_READY_OUT(REQ_READY_OUT), .RAS_N_OUT(RAS_N_OUT),
    .CAS_N_OUT(CAS_N_OUT), .WE_N_OUT(WE_N_OUT), .ADDR_OUT(ADDR_OUT),
    .DIN_OUT(DIN_OUT));

// ---- dv/drc_mem_model.sv ----
// behavioural model of the 8K x 1 multiplexed-address memory
`timescale 1ns/1ps
module drc_mem_model #(
    parameter logic HALF_SELECT = 1'b1 // level expected on the top line
) (
    input  wire logic       ras_n_in, // row strobe
    input  wire logic       cas_n_in, // column strobe
    input  wire logic       we_n_in,  // write strobe
    input  wire logic [6:0] addr_in,  // muxed address
    input  wire logic       din_in,   // write data
    output logic            dout_out  // read data
);
    logic        mem_r [0:8191];  // cell array
    logic [5:0]  row_r;           // latched row
    logic [12:0] word_r;          // latched word address
    logic        bit_r = 1'b0;    // bit read out
    logic        early_r = 1'b0;  // cycle is an early write
    logic        col_r = 1'b0;    // column strobe seen in this cycle
    logic        on_r = 1'b0;     // output driven
    time         ras_t;           // time of row strobe fall
    int          n_ras = 0;       // row strobe cycles
    int          n_row_only = 0;  // row-only refresh cycles
    int          n_bad_half = 0;  // row phases with wrong top line
    initial for (int i = 0; i < 8192; i++) mem_r[i] = 1'b0;
    // row strobe fall latches the row and checks the array half
    always @(negedge ras_n_in) begin
        ras_t = $time;
        #1; // address lines change in the same step as the strobe
        row_r = addr_in[5:0];
        col_r = 1'b0;
        n_ras++;
        if (addr_in[6] !== HALF_SELECT) n_bad_half++;
    end
    // a rise with no column strobe was a row-only refresh
    always @(posedge ras_n_in) if (!col_r && n_ras > 0) n_row_only++;
    // column strobe fall picks the word; an early write stores at once
    always @(negedge cas_n_in) begin
        #1; // strobes, address and data change in the same step
        if (!ras_n_in) begin
            col_r   = 1'b1;
            word_r  = {addr_in, row_r};
            early_r = !we_n_in;
            bit_r   = mem_r[word_r];
            if (early_r) mem_r[word_r] = din_in;
            else begin
                #135;
                if ($time - ras_t < 200) #(200 - ($time - ras_t));
                if (!cas_n_in) on_r = 1'b1;
            end
        end
    end
    // a late write strobe stores after the old bit was taken
    always @(negedge we_n_in) begin
        #2; // the column strobe fall settles the write mode first
        if (!cas_n_in && !ras_n_in && col_r && !early_r)
            mem_r[word_r] = din_in;
    end
    // output stays latched while the column strobe is low, across
    // row-only cycles too, and is released when it rises
    always @(posedge cas_n_in) on_r = 1'b0;
    // a released pin shows the inverse bit so an early sample fails
    assign dout_out = on_r ? bit_r : !bit_r;
endmodule : drc_mem_model

// ---- dv/tb_top.sv ----
// self-checking testbench for the strobe-cycle memory controller
`timescale 1ns/1ps
module tb_top;
    import drc_pkg::*;
    localparam int REF_IV = 50; // short refresh interval for the run
    logic        clk_in = 1'b0, reset_in = 1'b1, req_valid = 1'b0;
    logic [1:0]  req_cmd = 2'h0;        // command
    logic [12:0] req_addr = 13'h0000;   // word address
    logic        req_wdata = 1'b0;      // write bit
    logic        req_ready, rd_valid, rd_data, init_done; // user outputs
    logic        ras_n, cas_n, we_n, din, dout;           // memory pins
    logic [6:0]  addr;                                    // muxed address
    int          num_errors = 0, n_tests = 0;             // tallies
    always #25 clk_in = ~clk_in;
    drc_ctrl #(.HALF_SELECT(1'b1), .REF_INTERVAL(REF_IV)) drc_ctrl_inst (
        .CLK_IN(clk_in), .RESET_IN(reset_in), .REQ_VALID_IN(req_valid),
        .REQ_CMD_IN(req_cmd), .REQ_ADDR_IN(req_addr),
        .REQ_WDATA_IN(req_wdata), .REQ_READY_OUT(req_ready),
        .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data),
        .INIT_DONE_OUT(init_done), .RAS_N_OUT(ras_n), .CAS_N_OUT(cas_n),
        .WE_N_OUT(we_n), .ADDR_OUT(addr), .DIN_OUT(din), .DOUT_IN(dout));
    drc_mem_model #(.HALF_SELECT(1'b1)) drc_mem_model_inst (.ras_n_in(ras_n),
        .cas_n_in(cas_n), .we_n_in(we_n), .addr_in(addr), .din_in(din),
        .dout_out(dout));
    task automatic give_verdict;
        if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t bit %b expected %b", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic cmp_cnt(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("BAD %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : cmp_cnt
    // bounded wait for a flag sampled at falling edges, once settled
    task automatic wait_hi(ref logic sig, input int n);
        int i;
        i = 0;
        do begin @(negedge clk_in); i++; end while (sig !== 1'b1 && i < n);
        cmp_bit(sig, 1'b1);
    endtask : wait_hi
    // request held until ready is seen, released in that same low phase
    task automatic do_req(input logic [1:0] c, input logic [12:0] a,
                          input logic wd);
        @(negedge clk_in);
        req_valid = 1'b1;
        req_cmd   = c;
        req_addr  = a;
        req_wdata = wd;
        wait_hi(req_ready, 600);
        req_valid = 1'b0;
    endtask : do_req
    task automatic rd_chk(input logic [1:0] c, input logic [12:0] a,
                          input logic wd, input logic exp);
        do_req(c, a, wd);
        wait_hi(rd_valid, 40);
        cmp_bit(rd_data, exp);
    endtask : rd_chk
    // request presented during warm-up waits for eight refreshes
    task automatic t_warmup;
        int n0;
        n0 = drc_mem_model_inst.n_ras;
        do_req(DRC_CMD_WRITE, 13'h0000, 1'b1);
        cmp_cnt(drc_mem_model_inst.n_ras - n0, 9, 11);
        cmp_bit(init_done, 1'b1);
    endtask : t_warmup
    // corner addresses written then read back to back
    task automatic t_write_read;
        logic [12:0] ad [4] = '{13'h0000, 13'h1FFF, 13'h0A55, 13'h15AA};
        logic        dv [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        foreach (ad[i]) do_req(DRC_CMD_WRITE, ad[i], dv[i]);
        foreach (ad[i]) rd_chk(DRC_CMD_READ, ad[i], 1'b0, dv[i]);
    endtask : t_write_read
    // read-modify-write returns the old bit and stores the new one
    task automatic t_rmw;
        rd_chk(DRC_CMD_RMW, 13'h0A55, 1'b1, 1'b0);
        rd_chk(DRC_CMD_READ, 13'h0A55, 1'b0, 1'b1);
        rd_chk(DRC_CMD_RMW, 13'h0A55, 1'b0, 1'b1);
        rd_chk(DRC_CMD_READ, 13'h0A55, 1'b0, 1'b0);
    endtask : t_rmw
    // idle span must be filled with row-only refreshes
    task automatic t_refresh;
        int n0;
        n0 = drc_mem_model_inst.n_row_only;
        repeat (4 * REF_IV) @(negedge clk_in);
        cmp_cnt(drc_mem_model_inst.n_row_only - n0, 3, 5);
        cmp_cnt(drc_mem_model_inst.n_bad_half, 0, 0);
        rd_chk(DRC_CMD_READ, 13'h1FFF, 1'b0, 1'b1);
    endtask : t_refresh
    // reset in mid-run restarts the warm-up before any request
    task automatic t_reset;
        int n0;
        @(negedge clk_in);
        reset_in = 1'b1;
        repeat (2) @(negedge clk_in);
        cmp_bit(init_done, 1'b0);
        cmp_bit(ras_n, 1'b1);
        reset_in = 1'b0;
        n0 = drc_mem_model_inst.n_ras;
        rd_chk(DRC_CMD_READ, 13'h15AA, 1'b0, 1'b1);
        cmp_cnt(drc_mem_model_inst.n_ras - n0, 9, 11);
    endtask : t_reset
    initial begin
        #(20000 * 50);
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (12) @(negedge clk_in);
        reset_in = 1'b0;
        t_warmup();
        t_write_read();
        t_rmw();
        t_refresh();
        t_reset();
        give_verdict();
    end
endmodule : tb_top
